// >>> rtl/tpu_pkg.sv
// Types shared by the timer PWM unit
package tpu_pkg;
    typedef enum logic [1:0] {
        TPU_LOG = 2'h0,
        TPU_LIN = 2'h1,
        TPU_FREQ = 2'h2,
        TPU_SPLIT = 2'h3
    } tpu_mode_t;
    typedef struct packed {
        logic gate;
        logic cnt_sel;
        tpu_mode_t mode;
    } tpu_tmode_t;
    typedef struct packed {
        logic [1:0] gate_in;
        logic [1:0] pin_in;
    } tpu_async_t;
endpackage

// >>> rtl/tpu_prescale.sv
// Shared timer prescaler with per-timer double-rate selection
`timescale 1ns/1ps
`default_nettype none
module tpu_prescale #(
    parameter int PW = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [PW-1:0] presc_set,
    input wire logic compat,
    input wire logic [1:0] double_rate,
    output logic [1:0] tick
);
    logic [PW-1:0] cnt_q;
    logic half_q;
    logic base;

    assign base = (cnt_q == presc_set);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            half_q <= 1'h0;
        end else if (ce) begin
            cnt_q <= base ? '0 : PW'(cnt_q + 1'h1);
            if (base) begin
                half_q <= ~half_q;
            end
        end
    end

    // Compatibility mode: double rate halves the tick rate
    for (genvar g = 0; g < 2; g++) begin : g_tick
        assign tick[g] = compat ? (base & (~double_rate[g] | half_q))
                                : (double_rate[g] ? base : 1'h1); // R18
    end
endmodule
`default_nettype wire

// >>> rtl/tpu_regs.svh
// Register offsets, field positions and reset values of the timer PWM unit
// What this block does
// R1 - PWM enable turns timer into 8-bit PWM
// R2 - PWM waveform drives the timer count pin
// R3 - Software selects timer source, pin output
// R4 - Overflow flags and baud source keep working
// R5 - Inactive gate input halts counter and waveform
// R6 - Timer mode bits select four PWM modes
// R7 - High at wrap to zero, low on match
// R8 - Duty copied to compare only on wrap
// R9 - Zero duty holds low, else duty/256
// R10 - Mode 0 logarithmic low-byte prescaler
// R11 - Mode 1 linear prescaler with low reload
// R12 - Mode 2 auto-reload, toggle on low overflow
// R13 - Second timer in mode 3 holds count
// R14 - First timer mode 3 splits into two counters
// R15 - Split mode duties from low, high reloads
// R16 - Split period fixed at 256 prescaled clocks
// R17 - Split mode: second timer raises no flag
// R18 - Shared prescaler, double-rate bit, compatibility mode
// R19 - Prescale field sets active low bits minus one
// R20 - PWM enables at control bits 7 and 6
// R21 - Compare register resets to zero
`ifndef TPU_REGS_SVH
`define TPU_REGS_SVH
`define TPU_OFF_CTLB 8'h00
`define TPU_OFF_TMODE 8'h04
`define TPU_OFF_CTRL 8'h08
`define TPU_OFF_RELOAD 8'h0C
`define TPU_OFF_COUNT 8'h10
`define TPU_OFF_STATUS 8'h14
`define TPU_CTLB_RST 8'h24
`define TPU_TMODE_RST 8'h00
`define TPU_CTRL_RST 12'h000
`define TPU_CTRL_MASK 12'hF1F
`define TPU_RELOAD_RST 32'h0000_0000
`define TPU_CTLB_PWM1 7
`define TPU_CTLB_PWM0 6
`define TPU_PSC_W 3
`define TPU_CTRL_RUN 0
`define TPU_CTRL_X2 2
`define TPU_CTRL_COMPAT 4
`define TPU_CTRL_PRE 8
`define TPU_PRE_W 4
`endif

// >>> rtl/tpu_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tpu_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    // First stage feeds only the second
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q <= '0;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q <= (q & ~agree) | (s3_q & agree);
        end
    end
endmodule
`default_nettype wire

// >>> rtl/tpu_top.sv
// Timer PWM output unit: two timers, four PWM modes, APB registers
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tpu_regs.svh"
module tpu_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic first_timer_pin_sense,
    output logic first_timer_pin_drive,
    output logic first_timer_pin_drive_en,
    input wire logic second_timer_pin_sense,
    output logic second_timer_pin_drive,
    output logic second_timer_pin_drive_en,
    input wire logic first_gate_input,
    input wire logic second_gate_input,
    output logic first_overflow_flag,
    output logic second_overflow_flag,
    output logic baud_tick
);
    logic [7:0] timer_control_b_q;
    logic [7:0] timer_mode_register_q;
    logic [11:0] ctrl_q;
    logic [31:0] reload_q;
    logic [7:0] lo_q [2];
    logic [7:0] hi_q [2];
    logic [7:0] lo_d [2];
    logic [7:0] hi_d [2];
    logic [7:0] cmp_q [2];
    logic [7:0] cmp_side_q;
    logic [1:0] wave_q;
    logic wave_side_q;
    logic [1:0] flag_q;
    logic [1:0] pin_wave_q;
    logic [1:0] pin_en_q;
    logic baud_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [1:0] pin_prev_q;
    tpu_pkg::tpu_tmode_t tm [2];
    tpu_pkg::tpu_async_t async_s;
    logic [3:0] sync_q;
    logic [1:0] pwm_en;
    logic [1:0] run;
    logic [1:0] run_ok;
    logic [1:0] src;
    logic [1:0] inc_lo;
    logic [1:0] tick;
    logic [1:0] fall;
    logic [1:0] lo_ov;
    logic [1:0] hi_st;
    logic [1:0] hi_ov;
    logic [1:0] ev;
    logic [1:0] mstep;
    logic [1:0] set;
    logic [1:0] clr;
    logic [7:0] rl [2];
    logic [7:0] rh [2];
    logic [7:0] mval [2];
    logic [7:0] mduty [2];
    logic [7:0] mask;
    logic split0;
    logic inc_hi0;
    logic wr_en;
    logic cnt_wr;
    logic [31:0] rdata;

    function automatic logic f_hit(input logic [7:0] a);
        logic h;
        h = 1'h0;
        case (a)
            `TPU_OFF_CTLB, `TPU_OFF_TMODE, `TPU_OFF_CTRL,
            `TPU_OFF_RELOAD, `TPU_OFF_COUNT, `TPU_OFF_STATUS: h = 1'h1;
            default: h = 1'h0;
        endcase
        return h;
    endfunction

    // Edge-aligned output: set at zero, cleared on compare match
    function automatic logic f_wave(input logic cur, input logic step,
                                    input logic [7:0] val, input logic [7:0] cmp,
                                    input logic [7:0] duty);
        logic nxt;
        nxt = cur;
        if (step && val == 8'h00) begin
            nxt = (duty != 8'h00);
        end else if (step && val == cmp) begin
            nxt = 1'h0;
        end
        return nxt;
    endfunction

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    tpu_sync #(.W(4)) u_sync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .d({second_gate_input, first_gate_input,
            second_timer_pin_sense, first_timer_pin_sense}),
        .q(sync_q)
    );

    tpu_prescale #(.PW(`TPU_PRE_W)) u_pre (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .presc_set(ctrl_q[`TPU_CTRL_PRE +: `TPU_PRE_W]),
        .compat(ctrl_q[`TPU_CTRL_COMPAT]),
        .double_rate(ctrl_q[`TPU_CTRL_X2 +: 2]),
        .tick(tick)
    );

    assign async_s = tpu_pkg::tpu_async_t'(sync_q);
    assign pwm_en = {timer_control_b_q[`TPU_CTLB_PWM1],
                     timer_control_b_q[`TPU_CTLB_PWM0]}; // R20 R1
    assign run = ctrl_q[`TPU_CTRL_RUN +: 2];
    assign fall = pin_prev_q & ~async_s.pin_in;
    assign split0 = (tm[0].mode == tpu_pkg::TPU_SPLIT);
    // Upper half of a split first timer only counts clocks
    assign inc_hi0 = run[1] & tick[0]; // R14
    assign wr_en = psel & penable & pready_q & pwrite & f_hit(paddr);
    assign cnt_wr = wr_en && (paddr == `TPU_OFF_COUNT);

    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign tm[g] = tpu_pkg::tpu_tmode_t'(timer_mode_register_q[4*g +: 4]); // R6
        assign rl[g] = reload_q[16*g +: 8];
        assign rh[g] = reload_q[16*g+8 +: 8];
        assign run_ok[g] = run[g] & (~tm[g].gate | async_s.gate_in[g]); // R5
        assign src[g] = tm[g].cnt_sel ? fall[g] : tick[g];
        assign inc_lo[g] = run_ok[g] & src[g];
        assign ev[g] = tm[g].mode[1] ? lo_ov[g] : hi_ov[g];
        assign mstep[g] = (g == 0 && split0) ? inc_lo[0] : hi_st[g];
        assign mval[g] = (g == 0 && split0) ? lo_d[0] : hi_d[g];
        assign mduty[g] = (g == 0 && split0) ? rl[0] : rh[g]; // R15
    end

    always_comb begin
        mask = 8'h00;
        for (int n = 0; n < 2; n++) begin
            lo_d[n] = lo_q[n];
            hi_d[n] = hi_q[n];
            lo_ov[n] = 1'h0;
            hi_st[n] = 1'h0;
            mask = 8'((9'h002 << timer_control_b_q[3*n +: `TPU_PSC_W]) - 9'h001); // R19
            unique case (tm[n].mode)
                tpu_pkg::TPU_LOG: begin
                    if (inc_lo[n]) begin
                        lo_d[n] = (lo_q[n] + 8'h01) & mask; // R10
                        lo_ov[n] = ((lo_q[n] & mask) == mask);
                        hi_st[n] = lo_ov[n];
                    end
                end
                tpu_pkg::TPU_LIN: begin
                    if (inc_lo[n] && lo_q[n] == 8'hFF) begin
                        lo_ov[n] = 1'h1;
                        hi_st[n] = 1'h1;
                        lo_d[n] = pwm_en[n] ? rl[n] : 8'h00; // R11
                    end else if (inc_lo[n]) begin
                        lo_d[n] = lo_q[n] + 8'h01;
                    end
                end
                tpu_pkg::TPU_FREQ: begin
                    if (inc_lo[n] && lo_q[n] == 8'hFF) begin
                        lo_ov[n] = 1'h1;
                        lo_d[n] = hi_q[n]; // R12
                    end else if (inc_lo[n]) begin
                        lo_d[n] = lo_q[n] + 8'h01;
                    end
                end
                tpu_pkg::TPU_SPLIT: begin
                    // Second timer simply holds here
                    if (n == 0) begin // R13
                        if (inc_lo[0]) begin
                            lo_d[0] = lo_q[0] + 8'h01; // R16
                            lo_ov[0] = (lo_q[0] == 8'hFF);
                        end
                        hi_st[0] = inc_hi0; // R14
                    end
                end
            endcase
            if (hi_st[n]) begin
                hi_d[n] = hi_q[n] + 8'h01;
            end
            hi_ov[n] = hi_st[n] & (hi_q[n] == 8'hFF);
            // Plain mode 1 is one 16-bit counter reloading both halves
            if (!pwm_en[n] && tm[n].mode == tpu_pkg::TPU_LIN && hi_ov[n]) begin
                hi_d[n] = rh[n];
                lo_d[n] = rl[n];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int n = 0; n < 2; n++) begin
                lo_q[n] <= 8'h00;
                hi_q[n] <= 8'h00;
            end
        end else if (ce) begin
            for (int n = 0; n < 2; n++) begin
                if (cnt_wr) begin
                    lo_q[n] <= pwdata[16*n +: 8];
                    hi_q[n] <= pwdata[16*n+8 +: 8];
                end else begin
                    lo_q[n] <= lo_d[n];
                    hi_q[n] <= hi_d[n];
                end
            end
        end
    end

    // Compare registers only load at wrap, so duty writes never glitch
    always_ff @(posedge clk) begin
        if (srst) begin
            wave_q <= 2'h0;
            wave_side_q <= 1'h0;
            cmp_side_q <= 8'h00; // R21
            for (int n = 0; n < 2; n++) begin
                cmp_q[n] <= 8'h00; // R21
            end
        end else if (ce) begin
            for (int n = 0; n < 2; n++) begin
                if (tm[n].mode == tpu_pkg::TPU_FREQ) begin
                    if (lo_ov[n]) begin
                        wave_q[n] <= ~wave_q[n]; // R12
                    end
                end else begin
                    wave_q[n] <= f_wave(wave_q[n], mstep[n], mval[n],
                                        cmp_q[n], mduty[n]); // R7 R9
                    if (mstep[n] && mval[n] == 8'h00) begin
                        cmp_q[n] <= mduty[n]; // R8
                    end
                end
            end
            wave_side_q <= f_wave(wave_side_q, split0 & hi_st[0], hi_d[0],
                                  cmp_side_q, rh[0]); // R15
            if (split0 && hi_st[0] && hi_d[0] == 8'h00) begin
                cmp_side_q <= rh[0]; // R8
            end
        end
    end

    // Pin drive follows the PWM enables; split mode steers upper half to pin two
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_wave_q <= 2'h0;
            pin_en_q <= 2'h0;
            pin_prev_q <= 2'h0;
            baud_q <= 1'h0;
        end else if (ce) begin
            pin_wave_q[0] <= wave_q[0]; // R2
            pin_wave_q[1] <= split0 ? wave_side_q : wave_q[1]; // R2 R14
            pin_en_q <= pwm_en; // R2 R20
            pin_prev_q <= async_s.pin_in;
            baud_q <= ev[1]; // R4 R17
        end
    end

    // Split first timer takes over the second flag
    assign set = {split0 ? hi_ov[0] : ev[1], ev[0]}; // R4 R17
    assign clr = (wr_en && paddr == `TPU_OFF_STATUS) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_q <= 2'h0;
        end else if (ce) begin
            flag_q <= (flag_q & ~clr) | set; // R4
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_control_b_q <= `TPU_CTLB_RST; // R19
            timer_mode_register_q <= `TPU_TMODE_RST;
            ctrl_q <= `TPU_CTRL_RST;
            reload_q <= `TPU_RELOAD_RST;
        end else if (ce && wr_en) begin
            case (paddr)
                `TPU_OFF_CTLB: timer_control_b_q <= pwdata[7:0]; // R1
                `TPU_OFF_TMODE: timer_mode_register_q <= pwdata[7:0];
                `TPU_OFF_CTRL: ctrl_q <= pwdata[11:0] & `TPU_CTRL_MASK;
                `TPU_OFF_RELOAD: reload_q <= pwdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (paddr)
            `TPU_OFF_CTLB: rdata = {24'h000000, timer_control_b_q};
            `TPU_OFF_TMODE: rdata = {24'h000000, timer_mode_register_q};
            `TPU_OFF_CTRL: rdata = {20'h00000, ctrl_q};
            `TPU_OFF_RELOAD: rdata = reload_q;
            `TPU_OFF_COUNT: rdata = {hi_q[1], lo_q[1], hi_q[0], lo_q[0]};
            `TPU_OFF_STATUS: rdata = {28'h0000000, pin_wave_q, flag_q};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase; read data is captured in the setup cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_q <= 1'h0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'h0;
        end else if (ce) begin
            if (psel && !penable && !pready_q) begin
                pready_q <= 1'h1;
                pslverr_q <= !f_hit(paddr);
                prdata_q <= pwrite ? 32'h0000_0000 : rdata;
            end else begin
                pready_q <= 1'h0;
                pslverr_q <= 1'h0;
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign first_timer_pin_drive = pin_wave_q[0];
    assign second_timer_pin_drive = pin_wave_q[1];
    assign first_timer_pin_drive_en = pin_en_q[0];
    assign second_timer_pin_drive_en = pin_en_q[1];
    assign first_overflow_flag = flag_q[0];
    assign second_overflow_flag = flag_q[1];
    assign baud_tick = baud_q;

    property p_pin_en;
        ce |=> first_timer_pin_drive_en == $past(timer_control_b_q[`TPU_CTLB_PWM0]);
    endproperty
    a_pin_en: assert property (p_pin_en) else $error("pin enable not from pwm enable"); // R2

    property p_zero_duty;
        ce && !split0 && tm[0].mode != tpu_pkg::TPU_FREQ && cmp_q[0] == 8'h00
            && rh[0] == 8'h00 && !wave_q[0] |=> !wave_q[0];
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty went high"); // R9

    property p_cmp_load;
        $changed(cmp_q[0]) |-> $past(mstep[0]) && $past(mval[0]) == 8'h00
            && cmp_q[0] == $past(mduty[0]);
    endproperty
    a_cmp_load: assert property (p_cmp_load) else $error("compare loaded off wrap"); // R8

    property p_rise;
        ce && tm[0].mode != tpu_pkg::TPU_FREQ && mstep[0] && mval[0] == 8'h00
            && mduty[0] != 8'h00 |=> wave_q[0];
    endproperty
    a_rise: assert property (p_rise) else $error("no rise at wrap"); // R7

    // Wave checked on the very next edge, pin one edge later; a later wrap may legally set them again
    property p_fall;
        ce && tm[0].mode != tpu_pkg::TPU_FREQ && mstep[0] && mval[0] != 8'h00
            && mval[0] == cmp_q[0] ##1 ce |-> !wave_q[0] ##1 !pin_wave_q[0];
    endproperty
    a_fall: assert property (p_fall) else $error("no fall on match"); // R7

    property p_toggle;
        ce && tm[1].mode == tpu_pkg::TPU_FREQ && lo_ov[1] |=> wave_q[1] != $past(wave_q[1]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle on overflow"); // R12

    property p_hold;
        ce && tm[1].mode == tpu_pkg::TPU_SPLIT && !cnt_wr
            |=> lo_q[1] == $past(lo_q[1]) && hi_q[1] == $past(hi_q[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("second timer moved in mode 3"); // R13

    property p_gate;
        ce && tm[0].gate && !async_s.gate_in[0] && !cnt_wr |=> $stable(lo_q[0]);
    endproperty
    a_gate: assert property (p_gate) else $error("gated counter moved"); // R5

    property p_split_flag;
        ce && split0 && !hi_ov[0] && !flag_q[1] |=> !flag_q[1];
    endproperty
    a_split_flag: assert property (p_split_flag) else $error("second flag from timer"); // R17

    property p_ovf;
        ce && ev[0] |=> flag_q[0];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // R4
endmodule
`default_nettype wire

// >>> tb/timer_pwm_output_unit_tb.sv
// Self-checking bench for the timer PWM unit over APB
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module timer_pwm_output_unit_tb;
    logic clk, srst, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, c1;
    logic drv0, en0, drv1, en1, lvl0, lvl1, gate0, gate1, fl0, fl1, baud;
    logic [31:0] hi0, per0, ris0, hi1, per1, ris1;
    logic [31:0] rst_val [6] = '{32'h24, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] m2_ctrl [5] = '{32'h001, 32'h101, 32'h105, 32'h111, 32'h115};
    logic [31:0] m2_per [5] = '{32'h8, 32'h8, 32'h10, 32'h10, 32'h20};
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    tpu_top dut (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .first_timer_pin_sense(lvl0),
        .first_timer_pin_drive(drv0), .first_timer_pin_drive_en(en0),
        .second_timer_pin_sense(lvl1), .second_timer_pin_drive(drv1),
        .second_timer_pin_drive_en(en1), .first_gate_input(gate0),
        .second_gate_input(gate1), .first_overflow_flag(fl0),
        .second_overflow_flag(fl1), .baud_tick(baud));
    tpu_load_model load0 (.clk(clk), .srst(srst), .drive(drv0), .drive_en(en0),
        .level(lvl0), .high_len(hi0), .period_len(per0), .rises(ris0));
    tpu_load_model load1 (.clk(clk), .srst(srst), .drive(drv1), .drive_en(en1),
        .level(lvl1), .high_len(hi1), .period_len(per1), .rises(ris1));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard; the whole sequence needs about 9000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            give_verdict();
        end
    end

    // Called right after a rising edge; holds the request until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wait_rise(input int k, input logic sel);
        logic [31:0] r0;
        repeat (k) begin
            r0 = sel ? ris1 : ris0;
            while ((sel ? ris1 : ris0) === r0) @(posedge clk);
        end
    endtask

    // Third rise leaves a whole period after any reconfiguration
    task automatic check_wave(input logic sel, input logic [31:0] p, input logic [31:0] h);
        wait_rise(3, sel);
        `CHK(sel ? per1 : per0, p)
        `CHK(sel ? hi1 : hi0, h)
    endtask

    initial begin
        srst = 1'h1;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        gate0 = 1'h1;
        gate1 = 1'h1;
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        `CHK(drv0, 1'h0)
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            `CHK(rd, rst_val[i])
        end
        apb(1'h0, 8'h18, 32'h0);
        `CHK({err, rd}, {1'h1, 32'h0})
        apb(1'h1, 8'h08, 32'h0000_0001);
        apb(1'h1, 8'h0C, 32'h0000_40FE);
        apb(1'h1, 8'h04, 32'h0000_0001);
        apb(1'h1, 8'h00, 32'h0000_0064);
        check_wave(1'h0, 32'h200, 32'h80);
        `CHK(en0, 1'h1)
        wait_rise(1, 1'h0);
        apb(1'h1, 8'h0C, 32'h0000_80FE);
        while (lvl0 === 1'h1) @(posedge clk);
        @(posedge clk);
        `CHK(hi0, 32'h80)
        check_wave(1'h0, 32'h200, 32'h100);
        apb(1'h1, 8'h0C, 32'h0000_00FE);
        repeat (1100) @(posedge clk);
        c1 = ris0;
        repeat (600) @(posedge clk);
        `CHK({ris0, lvl0}, {c1, 1'h0})
        apb(1'h1, 8'h00, 32'h0000_0060);
        apb(1'h1, 8'h04, 32'h0000_0000);
        apb(1'h1, 8'h0C, 32'h0000_8000);
        check_wave(1'h0, 32'h200, 32'h100);
        apb(1'h1, 8'h04, 32'h0000_0002);
        apb(1'h1, 8'h10, 32'h0000_FC00);
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 8'h08, m2_ctrl[i]);
            check_wave(1'h0, m2_per[i], m2_per[i] >> 1);
        end
        `CHK(fl0, 1'h1)
        gate0 <= 1'h0;
        apb(1'h1, 8'h04, 32'h0000_000A);
        repeat (10) @(posedge clk);
        apb(1'h0, 8'h10, 32'h0);
        c1 = rd;
        repeat (20) @(posedge clk);
        apb(1'h0, 8'h10, 32'h0);
        `CHK(rd[7:0], c1[7:0])
        apb(1'h1, 8'h14, 32'h0000_0001);
        `CHK({fl1, fl0}, 2'h0)
        gate0 <= 1'h1;
        check_wave(1'h0, 32'h20, 32'h10);
        apb(1'h1, 8'h00, 32'h0000_0024);
        repeat (2) @(posedge clk);
        `CHK(en0, 1'h0)
        apb(1'h1, 8'h00, 32'h0000_00E4);
        apb(1'h1, 8'h0C, 32'h0000_C040);
        apb(1'h1, 8'h04, 32'h0000_0033);
        apb(1'h1, 8'h08, 32'h0000_0003);
        check_wave(1'h0, 32'h100, 32'h40);
        check_wave(1'h1, 32'h100, 32'hC0);
        `CHK(fl1, 1'h1)
        apb(1'h0, 8'h10, 32'h0);
        c1 = rd;
        repeat (50) @(posedge clk);
        apb(1'h0, 8'h10, 32'h0);
        `CHK(rd[31:16], c1[31:16])
        apb(1'h1, 8'h04, 32'h0000_0023);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (baud === 1'h1) n++;
        end
        `CHK((n >= 2), 1'h1)
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> tb/tpu_load_model.sv
// Load on a timer output pin: resolves the wire level and measures pulses
`timescale 1ns/1ps
`default_nettype none
module tpu_load_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic drive,
    input wire logic drive_en,
    output logic level,
    output logic [31:0] high_len,
    output logic [31:0] period_len,
    output logic [31:0] rises
);
    logic prev_q;
    logic [31:0] run_q;
    // Released pin sits at the pull-up level, never at a stale value
    assign level = drive_en ? drive : 1'h1;
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_q <= 1'h1;
            run_q <= 32'h0;
            high_len <= 32'h0;
            period_len <= 32'h0;
            rises <= 32'h0;
        end else begin
            prev_q <= level;
            run_q <= run_q + 32'h1;
            if (level && !prev_q) begin
                period_len <= run_q;
                run_q <= 32'h1;
                rises <= rises + 32'h1;
            end
            if (!level && prev_q) begin
                high_len <= run_q;
            end
        end
    end
endmodule
`default_nettype wire
